// ---- shared/wdtm_map.vh ----
`ifndef WDTM_MAP_VH
`define WDTM_MAP_VH
// ----------------------------------------
// watchdog mode register map and timing
// ----------------------------------------
`define WDTM_BANK 4'hf
`define WDTM_MODE_OFS 4'hf
`define WDTM_TAP_LSB 0
`define WDTM_HALT_BIT 2
`define WDTM_STOP_BIT 3
`define WDTM_MODE_RESET 8'h01
`define WDTM_WINDOW_CYCLES 8'h3c
`define WDTM_WINDOW_CRYSTAL_CLOCK 8'h78
`define WDTM_TAP0_BITS 5'h0c
`define WDTM_TAP1_BITS 5'h0e
`define WDTM_TAP2_BITS 5'h10
`define WDTM_TAP3_BITS 5'h12
`endif

// ---- hw/wdtm_sync.v ----
// Purpose: two-stage synchroniser for a level crossing into the core clock
// Assumes: level inputs that stay stable for several core cycles
// Notes: first stage feeds only the second
module wdtm_sync (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_level,
  output wire o_level
);
  reg meta_reg;
  reg sync_reg;

  // ----------------------------------------
  // two flops, first read only by second
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= i_level;
      sync_reg <= meta_reg;
    end
  end

  assign o_level = sync_reg;
endmodule

// ---- hw/wdtm_timer.v ----
// Purpose: retriggerable one-shot watchdog with windowed mode register
// Assumes: i_rc_osc is a free-running rc oscillator level, slow vs core clock
// Notes: counting runs on rc edges detected in the core domain
//
// Summary of operation
// - the watchdog is a retriggerable one-shot that pulses a core reset at terminal count.
// - the watchdog idles until the first watchdog instruction, which enables it.
// - every later watchdog instruction refreshes the count, restarting it from zero.
// - the counter advances on the internal rc oscillator, not the processor clock.
// - executing the watchdog instruction updates the zero, sign and overflow flags.
// - mode bits 1:0 choose a counter tap that sets the minimum timeout.
// - mode bit 2 lets the watchdog count while the core is halted.
// - mode bit 3 lets the watchdog count while the core is stopped.
// - mode bits 7:4 are reserved and do nothing.
// - mode writes are taken only in the first 60 processor cycles after reset or recovery.
// - after that window the mode register is locked until the next reset or recovery.
// - the mode register is write-only and reads return zero.
// - the mode register decodes at offset 0fh of expanded bank f.
`include "wdtm_map.vh"
module wdtm_timer #(
  parameter WINDOW_CYCLES = `WDTM_WINDOW_CYCLES,
  parameter CNT_W = `WDTM_TAP3_BITS
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_rc_osc,
  input wire i_proc_cycle,
  input wire i_first_instr,
  input wire i_stop_recover,
  input wire i_wdt_instr,
  input wire i_halt,
  input wire i_stop,
  input wire i_wr,
  input wire i_rd,
  input wire [3:0] i_bank,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output wire o_rd_hit,
  output reg o_flag_upd,
  output reg o_flag_zero,
  output reg o_flag_sign,
  output reg o_flag_ovf,
  output wire o_enabled,
  output reg o_core_reset
);
  localparam WIN_W = 8;
  // only the low nibble of the reset mode is stored
  localparam [7:0] MODE_RST = `WDTM_MODE_RESET;
  reg [3:0] mode_reg;
  reg [3:0] mode_next;
  reg win_open_reg;
  reg [WIN_W-1:0] win_cnt_reg;
  reg en_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [CNT_W-1:0] cnt_next;
  reg rc_prev_reg;
  reg rst_next;
  wire rc_lvl;
  wire rc_edge;
  wire hit;
  wire run_ok;
  wire term;

  // ----------------------------------------
  // tap decode
  // ----------------------------------------
  // chosen counter bit that marks terminal count for a tap code
  function [4:0] wdtm_tap_bit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: wdtm_tap_bit = `WDTM_TAP0_BITS - 5'h01;
        2'h1: wdtm_tap_bit = `WDTM_TAP1_BITS - 5'h01;
        2'h2: wdtm_tap_bit = `WDTM_TAP2_BITS - 5'h01;
        default: wdtm_tap_bit = `WDTM_TAP3_BITS - 5'h01;
      endcase
    end
  endfunction

  // ----------------------------------------
  // rc oscillator edge detect
  // ----------------------------------------
  // rc clock crosses as a level, edge taken after the second stage
  wdtm_sync u_rc_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_level(i_rc_osc),
    .o_level(rc_lvl)
  );

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rc_prev_reg <= 1'b0;
    end else begin
      rc_prev_reg <= rc_lvl;
    end
  end

  assign rc_edge = rc_lvl & ~rc_prev_reg;

  // ----------------------------------------
  // mode register and write window
  // ----------------------------------------
  assign hit = (i_bank == `WDTM_BANK) && (i_addr == `WDTM_MODE_OFS);

  // reserved upper bits are simply not stored
  always @* begin
    mode_next = mode_reg;
    if (i_wr && hit && win_open_reg) begin
      mode_next = i_wdata[3:0];
    end
  end

  // window reopens on a reset or stop recovery; counts processor cycles
  // from the first instruction, a core reset from this block restarts it too
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_reg <= MODE_RST[3:0];
      win_open_reg <= 1'b1;
      win_cnt_reg <= {WIN_W{1'b0}};
    end else begin
      mode_reg <= mode_next;
      if (i_stop_recover || o_core_reset) begin
        win_open_reg <= 1'b1;
        win_cnt_reg <= {WIN_W{1'b0}};
      end else if (win_open_reg && (i_proc_cycle || i_first_instr) &&
                   (i_first_instr || win_cnt_reg != {WIN_W{1'b0}})) begin
        if (win_cnt_reg == WINDOW_CYCLES[WIN_W-1:0] - 8'h01) begin
          win_open_reg <= 1'b0;
        end
        win_cnt_reg <= win_cnt_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // read side: write-only location
  // ----------------------------------------
  assign o_rd_hit = i_rd & hit;

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // watchdog counter
  // ----------------------------------------
  assign run_ok = (~i_halt | mode_reg[`WDTM_HALT_BIT]) &
                  (~i_stop | mode_reg[`WDTM_STOP_BIT]);
  assign term = cnt_reg[wdtm_tap_bit(mode_reg[1:0])];
  assign o_enabled = en_reg;

  always @* begin
    cnt_next = cnt_reg;
    rst_next = 1'b0;
    if (i_wdt_instr) begin
      cnt_next = {CNT_W{1'b0}};
    end else if (en_reg && term) begin
      cnt_next = {CNT_W{1'b0}};
      rst_next = 1'b1;
    end else if (en_reg && rc_edge && run_ok) begin
      cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // enable is sticky until a reset; a watchdog reset disarms it again
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_reg <= 1'b0;
      cnt_reg <= {CNT_W{1'b0}};
      o_core_reset <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      o_core_reset <= rst_next;
      if (i_wdt_instr) begin
        en_reg <= 1'b1;
      end else if (rst_next) begin
        en_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // condition flags from the instruction
  // ----------------------------------------
  // result taken as zero: z set, s and v cleared
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flag_upd <= 1'b0;
      o_flag_zero <= 1'b0;
      o_flag_sign <= 1'b0;
      o_flag_ovf <= 1'b0;
    end else begin
      o_flag_upd <= i_wdt_instr;
      if (i_wdt_instr) begin
        o_flag_zero <= 1'b1;
        o_flag_sign <= 1'b0;
        o_flag_ovf <= 1'b0;
      end
    end
  end
endmodule

// ---- verification/wdtm_timer_monitor.sv ----
// Purpose: port checks of the watchdog timer
// Assumes: registered flags and reset pulse
// Notes: bound below to every timer
module wdtm_timer_monitor (
  input logic i_core_clk,
  input logic i_resetn,
  input logic i_wdt_instr,
  input logic [7:0] o_rdata,
  input logic o_flag_upd,
  input logic o_flag_zero,
  input logic o_flag_sign,
  input logic o_flag_ovf,
  input logic o_enabled,
  input logic o_core_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // flag pattern left by one instruction
  sequence s_flags;
    o_flag_upd && o_flag_zero && !o_flag_sign && !o_flag_ovf;
  endsequence
  // a cleared count cannot expire at once
  sequence s_quiet;
    !o_core_reset [*8];
  endsequence
  a_flag_update: assert property (i_wdt_instr |=> s_flags)
    else $error("flags");
  a_flag_cause: assert property (o_flag_upd |-> $past(i_wdt_instr))
    else $error("cause");
  a_instr_arms: assert property (i_wdt_instr |=> o_enabled)
    else $error("arm");
  a_refresh_quiet: assert property (i_wdt_instr |=> s_quiet)
    else $error("refresh");
  a_reset_armed: assert property (o_core_reset |-> $past(o_enabled))
    else $error("unarmed");
  a_reset_once: assert property (o_core_reset |=> !o_core_reset)
    else $error("pulse");
  a_reset_disarm: assert property (o_core_reset && !i_wdt_instr |=> !o_enabled)
    else $error("disarm");
  a_read_zero: assert property (o_rdata == 8'h00)
    else $error("rdata");
endmodule
bind wdtm_timer wdtm_timer_monitor mon_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_wdt_instr(i_wdt_instr), .o_rdata(o_rdata), .o_flag_upd(o_flag_upd),
  .o_flag_zero(o_flag_zero), .o_flag_sign(o_flag_sign), .o_flag_ovf(o_flag_ovf),
  .o_enabled(o_enabled), .o_core_reset(o_core_reset));

// ---- verification/wdtm_core_model.sv ----
// Purpose: processor core stand-in
// Assumes: two core clocks per processor cycle
// Notes: a bench request becomes a pulse next cycle
module wdtm_core_model (
  input logic i_core_clk,
  input logic i_resetn,
  input logic i_kick,
  output logic o_proc_cycle,
  output logic o_wdt_instr
);
  timeunit 1ns;
  timeprecision 1ns;
  // cycle strobe every second clock, instruction on request
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_proc_cycle <= 1'b0;
      o_wdt_instr <= 1'b0;
    end else begin
      o_proc_cycle <= !o_proc_cycle;
      o_wdt_instr <= i_kick;
    end
  end
endmodule

// ---- verification/tb.sv ----
// Purpose: bench for the watchdog timer
// Assumes: write window cut to 4 cycles
// Notes: rc runs at a quarter of the core rate
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, rc = 0, kick = 0, fi = 0, halt = 0, wr = 0, rd = 0;
  logic stp = 0, sr = 0;
  logic [3:0] bk = 0, ad = 0;
  logic [7:0] wd = 0, rdat;
  logic pc, wi, hit, fu, fz, fs, fv, en, cr;
  int n_fail = 0, samples_checked = 0, t;
  wdtm_core_model core_u (.i_core_clk(clk), .i_resetn(rstn), .i_kick(kick),
    .o_proc_cycle(pc), .o_wdt_instr(wi));
  wdtm_timer #(.WINDOW_CYCLES(4)) dut_u (.i_core_clk(clk), .i_resetn(rstn), .i_rc_osc(rc),
    .i_proc_cycle(pc), .i_first_instr(fi), .i_stop_recover(sr), .i_wdt_instr(wi),
    .i_halt(halt), .i_stop(stp), .i_wr(wr), .i_rd(rd), .i_bank(bk), .i_addr(ad),
    .i_wdata(wd), .o_rdata(rdat), .o_rd_hit(hit), .o_flag_upd(fu), .o_flag_zero(fz),
    .o_flag_sign(fs), .o_flag_ovf(fv), .o_enabled(en), .o_core_reset(cr));
  // rc edges never meet a core rising edge
  initial forever #20 clk = ~clk;
  initial forever #80 rc = ~rc;
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one strobe cycle; hit is combinational, so looked at at once
  task automatic acc(logic w, logic [3:0] b, logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    bk <= b;
    ad <= a;
    wd <= d;
    #1;
    chk("hit", {7'h0, !w && b == 4'hf && a == 4'hf}, {7'h0, hit});
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
    chk("rdata", 8'h00, rdat);
  endtask
  task automatic refresh;
    @(posedge clk);
    kick <= 1;
    @(posedge clk);
    kick <= 0;
    @(posedge clk);
    #1;
    chk("flags", 8'h0c, {4'h0, fu, fz, fs, fv});
    chk("armed", 8'h01, {7'h0, en});
  endtask
  // bounded wait for the core reset pulse
  task automatic wait_rst(int lim);
    t = 0;
    while (cr !== 1'b1 && t < lim) begin
      @(posedge clk);
      #1;
      t++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    fi <= 1;
    @(posedge clk);
    fi <= 0;
    #1;
    chk("idle", 8'h00, {7'h0, en});
    acc(1, 4'hf, 4'hf, 8'hf0);
    acc(1, 4'he, 4'hf, 8'h03);
    acc(0, 4'hf, 4'hf, 8'h00);
    acc(0, 4'he, 4'hf, 8'h00);
    acc(0, 4'hf, 4'he, 8'h00);
    repeat (20) @(posedge clk);
    acc(1, 4'hf, 4'hf, 8'h03);
    refresh();
    @(posedge clk);
    halt <= 1;
    wait_rst(8600);
    chk("halted", 8'h00, {7'h0, cr});
    @(posedge clk);
    halt <= 0;
    stp <= 1;
    wait_rst(8600);
    chk("stopped", 8'h00, {7'h0, cr});
    @(posedge clk);
    stp <= 0;
    repeat (2) begin
      wait_rst(7000);
      chk("kept", 8'h00, {7'h0, cr});
      refresh();
    end
    // tap 0: 2048 rc rises of 4 core cycles each
    wait_rst(9000);
    chk("expiry", 8'h01, {7'h0, t > 8150 && t < 8250});
    @(posedge clk);
    #1;
    chk("disarmed", 8'h00, {7'h0, en});
    // watchdog reset reopens the window: tap 1, counting kept in stop only
    @(posedge clk);
    fi <= 1;
    @(posedge clk);
    fi <= 0;
    acc(1, 4'hf, 4'hf, 8'h09);
    refresh();
    @(posedge clk);
    stp <= 1;
    wait_rst(34000);
    chk("tap1", 8'h01, {7'h0, t > 32700 && t < 32850});
    @(posedge clk);
    stp <= 0;
    fi <= 1;
    @(posedge clk);
    fi <= 0;
    // let the window lapse, then a stop recovery must reopen it
    repeat (10) @(posedge clk);
    sr <= 1;
    @(posedge clk);
    sr <= 0;
    fi <= 1;
    @(posedge clk);
    fi <= 0;
    acc(1, 4'hf, 4'hf, 8'h04);
    refresh();
    @(posedge clk);
    halt <= 1;
    wait_rst(9000);
    chk("recover", 8'h01, {7'h0, t > 8150 && t < 8250});
    finish_test();
  end
endmodule
